// [hdl/sadc_pkg.sv]
package sadc_pkg;
  // Channel select codes
  localparam logic [3:0] SADC_CH_SE_LAST   = 4'h7;
  localparam logic [3:0] SADC_CH_DIFF_01   = 4'hA;
  localparam logic [3:0] SADC_CH_DIFF_67   = 4'hD;
  localparam logic [3:0] SADC_CH_TRIM      = 4'hF;
  // Mux side codes: 0..7 inputs, 8 ground, F none
  localparam logic [3:0] SADC_SRC_GROUND   = 4'h8;
  localparam logic [3:0] SADC_SRC_TRIM     = 4'h9;
  localparam logic [3:0] SADC_SRC_NONE     = 4'hF;
  // Cycle lengths in half periods of the conversion clock
  localparam int         SADC_BITS         = 12;
  localparam logic [5:0] SADC_HALF_UNITY   = 6'h20;  // 16 clocks
  localparam logic [5:0] SADC_HALF_GAIN16  = 6'h35;  // 26.5 clocks
  localparam logic [5:0] SADC_HALF_SAR     = 6'h18;  // 12 bit decisions, 2 halves each
  localparam logic [5:0] SADC_HALF_AMP     = 6'h15;  // Amplifier track/hold stage
  localparam logic [11:0] SADC_RESULT_RST  = 12'h000;
  typedef enum logic [4:0] {
    SADC_IDLE  = 5'h01,
    SADC_AMP   = 5'h02,
    SADC_TRACK = 5'h04,
    SADC_SAR   = 5'h08,
    SADC_DONE  = 5'h10
  } sadc_state_t;
endpackage : sadc_pkg

// [hdl/sadc_step_if.sv]
`timescale 1ns/1ps
interface sadc_step_if;
  logic        start;
  logic        cmp_in;
  logic        busy;
  logic        last;
  logic [11:0] code;
  modport ctrl (output start, output cmp_in, input busy, input last, input code);
  modport sar  (input start, input cmp_in, output busy, output last, output code);
endinterface : sadc_step_if

// [hdl/sadc_sar_step.sv]
`timescale 1ns/1ps
// Successive approximation register: one bit per two half periods
module sadc_sar_step (
  input  wire logic  clk_sys,
  input  wire logic  rst_n,
  input  wire logic  clk_en,
  input  wire logic  half_tick,
  sadc_step_if.sar   step
);
  logic [11:0] code_reg,  code_next;
  logic [11:0] mask_reg,  mask_next;
  logic        phase_reg, phase_next;

  // Trial bit set, comparator decides on the second half
  always_comb begin
    code_next  = code_reg;
    mask_next  = mask_reg;
    phase_next = phase_reg;
    if (step.start) begin
      code_next  = 12'h800;
      mask_next  = 12'h800;
      phase_next = 1'b0;
    end else if (half_tick && mask_reg != 12'h000) begin
      phase_next = ~phase_reg;
      if (phase_reg) begin
        if (!step.cmp_in) code_next = code_reg & ~mask_reg;
        mask_next = mask_reg >> 1;
        if (mask_reg[0] == 1'b0) code_next = (step.cmp_in ? code_reg : code_reg & ~mask_reg)
                                             | (mask_reg >> 1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      code_reg  <= 12'h000;
      mask_reg  <= 12'h000;
      phase_reg <= 1'b0;
    end else if (clk_en) begin
      code_reg  <= code_next;
      mask_reg  <= mask_next;
      phase_reg <= phase_next;
    end
  end

  assign step.busy = (mask_reg != 12'h000);
  assign step.last = half_tick && phase_reg && mask_reg[0];
  assign step.code = code_next;
endmodule : sadc_sar_step

// [hdl/sadc_ctrl.sv]
`timescale 1ns/1ps
module sadc_ctrl (
  input  wire logic        clk_sys,       // Twice the conversion clock rate
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [3:0]  channel_select,
  input  wire logic        gain16_enable,
  input  wire logic        soft_start,     // One-cycle pulse from software
  input  wire logic        continuous_mode,
  input  wire logic        timer_start_enable,
  input  wire logic        timer_zero_output,
  input  wire logic        ext_start_enable,
  input  wire logic        external_convert_request,
  input  wire logic        done_clear,
  input  wire logic        comparator_out,
  output logic [3:0]       signal_source,
  output logic [3:0]       reference_source,
  output logic             pos_cap_track,
  output logic             neg_cap_track,
  output logic             amp_track,
  output logic             sar_hold,
  output logic             conv_busy,
  output logic             conv_done,
  output logic [11:0]      result_holding
);
  sadc_pkg::sadc_state_t state_reg, state_next;
  logic [5:0]  half_reg,   half_next;
  logic [3:0]  sig_reg,    sig_next;
  logic [3:0]  ref_reg,    ref_next;
  logic        pos_reg,    pos_next;
  logic        neg_reg,    neg_next;
  logic        amp_reg,    amp_next;
  logic        hold_reg,   hold_next;
  logic        busy_reg,   busy_next;
  logic        done_reg,   done_next;
  logic [11:0] res_reg,    res_next;
  logic        ext_s1_reg, ext_s2_reg, ext_s3_reg;
  logic        tmr_s1_reg, tmr_s2_reg, tmr_s3_reg;
  logic        trig;
  logic        sar_kick;
  logic [5:0]  total_half;

  sadc_step_if step ();

  sadc_sar_step u_sar (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .half_tick (1'b1),
    .step      (step.sar)
  );

  // Pin synchronisers and edge memory
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
      tmr_s1_reg <= 1'b0;
      tmr_s2_reg <= 1'b0;
      tmr_s3_reg <= 1'b0;
    end else if (clk_en) begin
      ext_s1_reg <= external_convert_request;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
      tmr_s1_reg <= timer_zero_output;
      tmr_s2_reg <= tmr_s1_reg;
      tmr_s3_reg <= tmr_s2_reg;
    end
  end

  // Start sources, only honoured while idle
  always_comb begin
    trig = soft_start
         | continuous_mode
         | (timer_start_enable & tmr_s2_reg & ~tmr_s3_reg)
         | (ext_start_enable & ext_s2_reg & ~ext_s3_reg);
  end

  assign total_half = gain16_enable ? sadc_pkg::SADC_HALF_GAIN16
                                    : sadc_pkg::SADC_HALF_UNITY;
  assign step.cmp_in = comparator_out;
  assign step.start  = sar_kick;

  // Channel decode, sequencer, result latch
  always_comb begin
    state_next = state_reg;
    half_next  = half_reg;
    sig_next   = sig_reg;
    ref_next   = ref_reg;
    pos_next   = 1'b0;
    neg_next   = 1'b0;
    amp_next   = 1'b0;
    hold_next  = 1'b0;
    busy_next  = busy_reg;
    done_next  = done_reg;
    res_next   = res_reg;
    sar_kick   = 1'b0;
    if (done_clear) done_next = 1'b0;
    if (channel_select <= sadc_pkg::SADC_CH_SE_LAST) begin
      sig_next = channel_select;
      ref_next = sadc_pkg::SADC_SRC_GROUND;
    end else if (channel_select >= sadc_pkg::SADC_CH_DIFF_01 &&
                 channel_select <= sadc_pkg::SADC_CH_DIFF_67) begin
      sig_next = {channel_select[2:0] - 3'h2, 1'b0};
      ref_next = {channel_select[2:0] - 3'h2, 1'b1};
    end else if (channel_select == sadc_pkg::SADC_CH_TRIM) begin
      sig_next = sadc_pkg::SADC_SRC_TRIM;
      ref_next = sadc_pkg::SADC_SRC_TRIM;
    end else begin
      sig_next = sadc_pkg::SADC_SRC_NONE;
      ref_next = sadc_pkg::SADC_SRC_NONE;
    end
    if (state_reg != sadc_pkg::SADC_IDLE) half_next = half_reg + 6'h01;
    case (state_reg)
      sadc_pkg::SADC_IDLE: begin
        half_next = 6'h00;
        busy_next = 1'b0;
        if (trig) begin
          busy_next  = 1'b1;
          state_next = gain16_enable ? sadc_pkg::SADC_AMP : sadc_pkg::SADC_TRACK;
          amp_next   = gain16_enable;
          pos_next   = ~gain16_enable;
          neg_next   = ~gain16_enable;
        end
      end
      sadc_pkg::SADC_AMP: begin
        amp_next = 1'b1;
        if (half_reg == sadc_pkg::SADC_HALF_AMP - 6'h01) begin
          state_next = sadc_pkg::SADC_TRACK;
          amp_next   = 1'b0;
          pos_next   = 1'b1;
          neg_next   = 1'b1;
        end
      end
      sadc_pkg::SADC_TRACK: begin
        pos_next = 1'b1;
        neg_next = 1'b1;
        if (half_reg == total_half - sadc_pkg::SADC_HALF_SAR - 6'h02) begin
          state_next = sadc_pkg::SADC_SAR;
          pos_next   = 1'b0;
          neg_next   = 1'b0;
          hold_next  = 1'b1;
          sar_kick   = 1'b1;
        end
      end
      sadc_pkg::SADC_SAR: begin
        hold_next = 1'b1;
        if (step.last) begin
          state_next = sadc_pkg::SADC_DONE;
          res_next   = step.code;
        end
      end
      sadc_pkg::SADC_DONE: begin
        done_next  = 1'b1;
        busy_next  = 1'b0;
        state_next = sadc_pkg::SADC_IDLE;
      end
      default: begin
        state_next = sadc_pkg::SADC_IDLE;
        busy_next  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= sadc_pkg::SADC_IDLE;
      half_reg  <= 6'h00;
      sig_reg   <= sadc_pkg::SADC_SRC_NONE;
      ref_reg   <= sadc_pkg::SADC_SRC_NONE;
      pos_reg   <= 1'b0;
      neg_reg   <= 1'b0;
      amp_reg   <= 1'b0;
      hold_reg  <= 1'b0;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
      res_reg   <= sadc_pkg::SADC_RESULT_RST;
    end else if (clk_en) begin
      state_reg <= state_next;
      half_reg  <= half_next;
      sig_reg   <= sig_next;
      ref_reg   <= ref_next;
      pos_reg   <= pos_next;
      neg_reg   <= neg_next;
      amp_reg   <= amp_next;
      hold_reg  <= hold_next;
      busy_reg  <= busy_next;
      done_reg  <= done_next;
      res_reg   <= res_next;
    end
  end

  assign signal_source    = sig_reg;
  assign reference_source = ref_reg;
  assign pos_cap_track    = pos_reg;
  assign neg_cap_track    = neg_reg;
  assign amp_track        = amp_reg;
  assign sar_hold         = hold_reg;
  assign conv_busy        = busy_reg;
  assign conv_done        = done_reg;
  assign result_holding   = res_reg;
endmodule : sadc_ctrl

// [verification/sadc_ctrl_properties.sv]
`timescale 1ns/1ps
// Watches the controller pins for mux, staging and timing slips
module sadc_ctrl_properties (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic [3:0]  channel_select,
  input wire logic        gain16_enable,
  input wire logic        done_clear,
  input wire logic [3:0]  signal_source,
  input wire logic [3:0]  reference_source,
  input wire logic        pos_cap_track,
  input wire logic        neg_cap_track,
  input wire logic        amp_track,
  input wire logic        sar_hold,
  input wire logic        conv_busy,
  input wire logic        conv_done,
  input wire logic [11:0] result_holding
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [6:0] busy_cnt_reg;
  logic [6:0] busy_cnt_next;
  // Enabled clk_sys cycles of the current busy stretch; frozen cycles do not count
  always_comb begin
    busy_cnt_next = conv_busy ? busy_cnt_reg + {6'h00, clk_en} : 7'h00;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) busy_cnt_reg <= 7'h00;
    else busy_cnt_reg <= busy_cnt_next;
  end
  // First stage of each gain setting
  sequence unity_track_s;
    pos_cap_track && neg_cap_track && !sar_hold && !amp_track;
  endsequence
  sequence amp_stage_s;
    amp_track && !sar_hold;
  endsequence
  mux_single_a: assert property (clk_en && channel_select <= 4'h7 |=>
    signal_source == $past(channel_select) && reference_source == sadc_pkg::SADC_SRC_GROUND)
    else $error("single-ended routing wrong");
  mux_pair_a: assert property (clk_en && channel_select inside {[4'hA:4'hD]} |=>
    signal_source == ($past(channel_select) - 4'hA) * 4'h2
    && reference_source == signal_source + 4'h1) else $error("pair routing wrong");
  mux_reserved_a: assert property (clk_en && channel_select inside {4'h8, 4'h9, 4'hE} |=>
    signal_source == 4'hF && reference_source == 4'hF) else $error("reserved code routed");
  unity_start_a: assert property ($rose(conv_busy) && !gain16_enable |-> unity_track_s)
    else $error("unity cycle not tracking");
  gain_start_a: assert property ($rose(conv_busy) && gain16_enable |-> amp_stage_s)
    else $error("gain cycle not on amplifier");
  hold_excl_a: assert property (sar_hold |-> !pos_cap_track && !amp_track)
    else $error("tracking during hold");
  cycle_len_a: assert property ($fell(conv_busy) |->
    busy_cnt_reg == (gain16_enable ? 7'h35 : 7'h20)) else $error("cycle length wrong");
  result_done_a: assert property ($changed(result_holding) |=> conv_done && !conv_busy)
    else $error("result moved without done");
  done_clear_a: assert property (clk_en && done_clear && conv_done && !conv_busy |=>
    !conv_done) else $error("done flag not cleared");
endmodule : sadc_ctrl_properties

bind sadc_ctrl sadc_ctrl_properties i_sadc_ctrl_properties (.clk_sys, .rst_n, .clk_en,
  .channel_select, .gain16_enable, .done_clear, .signal_source, .reference_source,
  .pos_cap_track, .neg_cap_track, .amp_track, .sar_hold, .conv_busy, .conv_done,
  .result_holding);

// [verification/sadc_analog_model.sv]
`timescale 1ns/1ps
// Even inputs sit at full scale; odd inputs, ground and trim sit at zero
module sadc_analog_model (
  input  wire logic       clk_sys,
  input  wire logic [3:0] signal_source,
  input  wire logic [3:0] reference_source,
  input  wire logic       sar_hold,
  output logic            comparator_out
);
  logic toggle = 1'b0;
  // Outside hold the comparator line wanders every cycle
  always @(posedge clk_sys) toggle <= ~toggle;
  assign comparator_out = sar_hold ? (!signal_source[0] && signal_source < 4'h8
    && (reference_source[0] || reference_source > 4'h7)) : toggle;
endmodule : sadc_analog_model

// [verification/testbench.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t got %0h expected %0h", $time, g, e); end end
module testbench;
  logic        clk_sys, rst_n, clk_en, gain16_enable, soft_start, continuous_mode;
  logic        timer_start_enable, timer_zero_output, ext_start_enable, done_clear;
  logic        external_convert_request, comparator_out, pos_cap_track, neg_cap_track;
  logic        amp_track, sar_hold, conv_busy, conv_done;
  logic [3:0]  channel_select, signal_source, reference_source, exp_sig, exp_ref;
  logic [11:0] result_holding;
  int          mismatches = 0;
  int          n_compared = 0;
  sadc_ctrl i_sadc_ctrl (.clk_sys, .rst_n, .clk_en, .channel_select, .gain16_enable,
    .soft_start, .continuous_mode, .timer_start_enable, .timer_zero_output, .ext_start_enable,
    .external_convert_request, .done_clear, .comparator_out, .signal_source, .reference_source,
    .pos_cap_track, .neg_cap_track, .amp_track, .sar_hold, .conv_busy, .conv_done,
    .result_holding);
  sadc_analog_model i_sadc_analog_model (.clk_sys, .signal_source, .reference_source,
    .sar_hold, .comparator_out);
  // Clock and hang guard
  always #25 clk_sys = ~clk_sys;
  initial begin
    #(4000 * 50);
    mismatches++;
    close_out();
  end
  task step(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : step
  task pulse_start();
    soft_start = 1'b1;
    step(1);
    soft_start = 1'b0;
  endtask : pulse_start
  // Times one conversion, poking a start while busy, then checks the result
  task conv(input logic [5:0] len, input logic [11:0] res);
    int n;
    n = 0;
    while (!conv_busy && n < 10) begin n++; step(1); end
    n = 0;
    while (conv_busy && n < 99) begin soft_start = (n == 4); n++; step(1); end
    soft_start = 1'b0;
    `CHK(n[5:0], len)
    step(2);
    `CHK(conv_done, 1'b1)
    `CHK(result_holding, res)
  endtask : conv
  task close_out();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  // Main sequence
  initial begin
    {clk_sys, rst_n, gain16_enable, soft_start, continuous_mode, timer_start_enable} = '0;
    {timer_zero_output, ext_start_enable, done_clear, external_convert_request} = '0;
    clk_en = 1'b1;
    channel_select = 4'h0;
    step(6);
    `CHK(signal_source, sadc_pkg::SADC_SRC_NONE)
    `CHK(result_holding, sadc_pkg::SADC_RESULT_RST)
    rst_n = 1'b1;
    for (int i = 0; i < 16; i++) begin
      channel_select = i[3:0];
      exp_sig = i < 8 ? i[3:0] : (i > 9 && i < 14) ? 4'((i - 10) * 2) :
        i == 15 ? sadc_pkg::SADC_SRC_TRIM : sadc_pkg::SADC_SRC_NONE;
      exp_ref = i < 8 ? sadc_pkg::SADC_SRC_GROUND : (i > 9 && i < 14) ? exp_sig + 4'h1 :
        i == 15 ? sadc_pkg::SADC_SRC_TRIM : sadc_pkg::SADC_SRC_NONE;
      step(2);
      `CHK(signal_source, exp_sig)
      `CHK(reference_source, exp_ref)
    end
    channel_select = 4'h0;
    pulse_start();
    conv(sadc_pkg::SADC_HALF_UNITY, 12'hFFF);
    step(3);
    `CHK(conv_busy, 1'b0)
    done_clear = 1'b1;
    step(1);
    done_clear = 1'b0;
    step(1);
    `CHK(conv_done, 1'b0)
    channel_select = 4'h1;
    pulse_start();
    // Freeze in track: the cycle must resume where it stopped, not advance
    clk_en = 1'b0;
    step(5);
    `CHK(pos_cap_track, 1'b1)
    clk_en = 1'b1;
    conv(sadc_pkg::SADC_HALF_UNITY, 12'h000);
    gain16_enable = 1'b1;
    channel_select = 4'hA;
    pulse_start();
    conv(sadc_pkg::SADC_HALF_GAIN16, 12'hFFF);
    gain16_enable = 1'b0;
    external_convert_request = 1'b1;
    step(8);
    `CHK(conv_busy, 1'b0)
    external_convert_request = 1'b0;
    ext_start_enable = 1'b1;
    step(2);
    external_convert_request = 1'b1;
    conv(sadc_pkg::SADC_HALF_UNITY, 12'hFFF);
    step(4);
    `CHK(conv_busy, 1'b0)
    {external_convert_request, ext_start_enable} = 2'h0;
    {timer_start_enable, timer_zero_output} = 2'h3;
    conv(sadc_pkg::SADC_HALF_UNITY, 12'hFFF);
    {timer_start_enable, timer_zero_output} = 2'h0;
    continuous_mode = 1'b1;
    conv(sadc_pkg::SADC_HALF_UNITY, 12'hFFF);
    `CHK(conv_busy, 1'b1)
    continuous_mode = 1'b0;
    step(80);
    `CHK(conv_busy, 1'b0)
    close_out();
  end
endmodule : testbench
